// File: common/apcl_map.svh
`ifndef APCL_MAP_SVH
`define APCL_MAP_SVH

// ====================================================
// Timing
`define APCL_CLK_NS        10
`define APCL_WRITE_MIN_NS  100
`define APCL_WRITE_MIN_CYC \
  ((`APCL_WRITE_MIN_NS + `APCL_CLK_NS - 1) / `APCL_CLK_NS)
`define APCL_RDY_MAX_NS    60
`define APCL_RDY_MAX_CYC   (`APCL_RDY_MAX_NS / `APCL_CLK_NS)
`define APCL_CONFIG_CLOCK_DIV      8
`define APCL_BUSY_MIN      2
`define APCL_BUSY_MAX      9
`define APCL_INIT_CLR_CYC  64
// ====================================================
// Data layout
`define APCL_BYTE_BITS     8
`define APCL_STAT_READY    0
`endif

// File: common/apcl_pkg.sv
package apcl_pkg;
  // ==================================================
  // Access decoded at the device pins
  typedef enum logic [1:0] {
    ACC_IDLE,
    ACC_WRITE,
    ACC_READ
  } apcl_acc_type;

  // ==================================================
  // Host sequencer
  typedef enum logic [2:0] {
    HST_INIT,
    HST_IDLE,
    HST_WRITE,
    HST_WAIT_BUSY
  } apcl_hst_type;
endpackage : apcl_pkg

// File: common/apcl_if.sv
`timescale 1ns/100ps
interface apcl_if;
  logic       select_active_low;
  logic       select_active_high;
  logic       write_strobe_n;
  logic       read_strobe_n;
  logic [7:0] host_data;
  logic       host_data_oe;
  logic [7:0] dev_data;
  logic       dev_data_oe;
  logic [7:0] data_bus;
  logic       rdy_busy;
  logic       init_oe;
  logic       init_level;
  logic       config_clock;
  logic       serial_out;

  // Bus level from the enables; open-drain init with pull-up
  assign data_bus   = dev_data_oe ? dev_data :
                      (host_data_oe ? host_data : 8'hff);
  assign init_level = ~init_oe;

  modport device (
    input  select_active_low, select_active_high, write_strobe_n,
    input  read_strobe_n, data_bus, init_level,
    output dev_data, dev_data_oe, rdy_busy, init_oe,
    output config_clock, serial_out
  );
  modport host (
    output select_active_low, select_active_high, write_strobe_n,
    output read_strobe_n, host_data, host_data_oe,
    input  data_bus, rdy_busy, init_level
  );
endinterface : apcl_if

// File: design/apcl_device.sv
`timescale 1ns/100ps
`include "apcl_map.svh"
module apcl_device (
  input  wire logic clk,
  input  wire logic rst_n,
  apcl_if.device    bus,
  output logic      cfg_bit,
  output logic      cfg_bit_valid,
  output logic      init_busy,
  output logic      write_dropped
);
  localparam int BB = `APCL_BYTE_BITS;

  // ==================================================
  // Pin synchronisers (two flops each)
  logic [11:0] pin_meta_reg;
  logic [11:0] pin_sync_reg;
  logic [11:0] pin_raw;
  assign pin_raw = {bus.select_active_low, bus.select_active_high,
                    bus.write_strobe_n, bus.read_strobe_n,
                    bus.data_bus};

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      pin_meta_reg <= 12'hfff;
      pin_sync_reg <= 12'hfff;
    end else begin
      pin_meta_reg <= pin_raw;
      pin_sync_reg <= pin_meta_reg;
    end
  end

  logic       sel_lo_s;
  logic       sel_hi_s;
  logic       wr_n_s;
  logic       rd_n_s;
  logic [7:0] data_s;
  assign sel_lo_s = pin_sync_reg[11];
  assign sel_hi_s = pin_sync_reg[10];
  assign wr_n_s   = pin_sync_reg[9];
  assign rd_n_s   = pin_sync_reg[8];
  assign data_s   = pin_sync_reg[7:0];

  // ==================================================
  // Access decode
  apcl_pkg::apcl_acc_type acc;
  always_comb begin
    acc = apcl_pkg::ACC_IDLE;
    if (!sel_lo_s && sel_hi_s && !wr_n_s && rd_n_s)
      acc = apcl_pkg::ACC_WRITE;
    else if (!sel_lo_s && sel_hi_s && !rd_n_s)
      acc = apcl_pkg::ACC_READ;
  end

  // Length of the running write, saturating
  logic [7:0] wr_len_reg;
  logic       wr_act_reg;
  logic       in_full_reg;
  logic [7:0] wr_byte_reg;
  logic       wr_end;
  assign wr_end = wr_act_reg && (acc != apcl_pkg::ACC_WRITE);

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      wr_act_reg <= 1'b0;
      wr_len_reg <= 8'h00;
    end else begin
      wr_act_reg <= (acc == apcl_pkg::ACC_WRITE);
      if (acc != apcl_pkg::ACC_WRITE)
        wr_len_reg <= 8'h00;
      else if (wr_len_reg != 8'hff)
        wr_len_reg <= wr_len_reg + 8'h01;
    end
  end

  // Data is sampled every write cycle, so the last sample before
  // the strobe rises is the byte kept; no hold is needed
  always_ff @(posedge clk) begin
    if (!rst_n)
      wr_byte_reg <= 8'h00;
    else if (acc == apcl_pkg::ACC_WRITE)
      wr_byte_reg <= data_s;
  end

  logic accept;
  assign accept = wr_end && (wr_len_reg >= 8'(`APCL_WRITE_MIN_CYC))
                  && !in_full_reg && !init_busy;

  // ==================================================
  // Config clock divider; tick is the rising edge of config_clock
  logic [2:0] div_reg;
  logic       tick;
  assign tick = (div_reg == 3'h0);

  always_ff @(posedge clk) begin
    if (!rst_n)
      div_reg <= 3'h0;
    else
      div_reg <= div_reg + 3'h1;
  end

  always_ff @(posedge clk) begin
    if (!rst_n)
      bus.config_clock <= 1'b0;
    else
      bus.config_clock <= (div_reg < 3'(`APCL_CONFIG_CLOCK_DIV / 2));
  end

  // ==================================================
  // Init clearing: pin pulled low, never driven high
  logic [6:0] init_cnt_reg;
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      init_cnt_reg <= 7'h00;
      init_busy    <= 1'b1;
      bus.init_oe  <= 1'b1;
    end else begin
      if (init_cnt_reg != 7'(`APCL_INIT_CLR_CYC))
        init_cnt_reg <= init_cnt_reg + 7'h01;
      init_busy   <= (init_cnt_reg != 7'(`APCL_INIT_CLR_CYC));
      bus.init_oe <= (init_cnt_reg != 7'(`APCL_INIT_CLR_CYC));
    end
  end

  // ==================================================
  // Double-buffered converter: input stage and shifter
  logic [BB-1:0] in_byte_reg;
  logic [BB-1:0] sh_byte_reg;
  logic [3:0]   sh_cnt_reg;
  logic         handover;
  // Handover waits for the shifter's last bit and the next tick,
  // so the start delay follows shifter state and divider phase
  assign handover = tick && in_full_reg && (sh_cnt_reg <= 4'h1);

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      in_full_reg <= 1'b0;
      in_byte_reg <= '0;
    end else if (accept) begin
      in_full_reg <= 1'b1;
      in_byte_reg <= wr_byte_reg;
    end else if (handover) begin
      in_full_reg <= 1'b0;
    end
  end

  // MSB first, one bit per config clock
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      sh_byte_reg <= '0;
      sh_cnt_reg  <= 4'h0;
    end else if (handover) begin
      sh_byte_reg <= in_byte_reg;
      sh_cnt_reg  <= 4'(BB);
    end else if (tick && sh_cnt_reg != 4'h0) begin
      sh_byte_reg <= {sh_byte_reg[BB-2:0], 1'b0};
      sh_cnt_reg  <= sh_cnt_reg - 4'h1;
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      cfg_bit        <= 1'b0;
      cfg_bit_valid  <= 1'b0;
      bus.serial_out <= 1'b0;
    end else begin
      cfg_bit_valid <= tick && (handover || sh_cnt_reg > 4'h1);
      if (handover) begin
        cfg_bit        <= in_byte_reg[BB-1];
        bus.serial_out <= in_byte_reg[BB-1];
      end else if (tick && sh_cnt_reg > 4'h1) begin
        cfg_bit        <= sh_byte_reg[BB-2];
        bus.serial_out <= sh_byte_reg[BB-2];
      end
    end
  end

  // ==================================================
  // Busy: counts ticks since acceptance for the 2-period floor;
  // the first tick may land one cycle after acceptance, so one
  // tick more than the floor guarantees two whole periods
  logic [3:0] busy_ticks_reg;
  always_ff @(posedge clk) begin
    if (!rst_n)
      busy_ticks_reg <= 4'h0;
    else if (accept)
      busy_ticks_reg <= 4'h0;
    else if (tick && busy_ticks_reg != 4'hf)
      busy_ticks_reg <= busy_ticks_reg + 4'h1;
  end

  // Low from one cycle after an accepted write ends; high only once the
  // input stage is empty again (the fall well inside 60 ns)
  always_ff @(posedge clk) begin
    if (!rst_n)
      bus.rdy_busy <= 1'b0;
    else if (accept || init_busy)
      bus.rdy_busy <= 1'b0;
    else if (!in_full_reg &&
             busy_ticks_reg > 4'(`APCL_BUSY_MIN))
      bus.rdy_busy <= 1'b1;
  end

  always_ff @(posedge clk) begin
    if (!rst_n)
      write_dropped <= 1'b0;
    else
      write_dropped <= wr_end && !accept;
  end

  // ==================================================
  // Status read-back on the data bus
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      bus.dev_data_oe <= 1'b0;
      bus.dev_data    <= 8'h00;
    end else begin
      bus.dev_data_oe <= (acc == apcl_pkg::ACC_READ);
      bus.dev_data    <= 8'(bus.rdy_busy) << `APCL_STAT_READY;
    end
  end
endmodule : apcl_device

// File: design/apcl_host.sv
`timescale 1ns/100ps
`include "apcl_map.svh"
module apcl_host (
  input  wire logic       clk,
  input  wire logic       rst_n,
  apcl_if.host            bus,
  input  wire logic       user_valid,
  input  wire logic [7:0] user_data,
  output logic            user_ready
);
  // ==================================================
  // Synchronise ready/busy and init
  logic [1:0] meta_reg;
  logic [1:0] sync_reg;
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      meta_reg <= 2'b00;
      sync_reg <= 2'b00;
    end else begin
      meta_reg <= {bus.rdy_busy, bus.init_level};
      sync_reg <= meta_reg;
    end
  end

  apcl_pkg::apcl_hst_type st_reg;
  logic [7:0] len_reg;
  logic [3:0] rdy_cnt_reg;

  // Counts write length and ready-high time
  always_ff @(posedge clk) begin
    if (!rst_n || st_reg != apcl_pkg::HST_WRITE) begin
      len_reg     <= 8'h00;
      rdy_cnt_reg <= 4'h0;
    end else begin
      if (len_reg != 8'hff)
        len_reg <= len_reg + 8'h01;
      if (!sync_reg[1])
        rdy_cnt_reg <= 4'h0;
      else if (rdy_cnt_reg != 4'hf)
        rdy_cnt_reg <= rdy_cnt_reg + 4'h1;
    end
  end

  // ==================================================
  // Sequencer
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      st_reg                 <= apcl_pkg::HST_INIT;
      bus.select_active_low  <= 1'b1;
      bus.select_active_high <= 1'b0;
      bus.write_strobe_n     <= 1'b1;
      bus.read_strobe_n      <= 1'b1;
      bus.host_data          <= 8'h00;
      bus.host_data_oe       <= 1'b0;
      user_ready             <= 1'b0;
    end else begin
      case (st_reg)
        apcl_pkg::HST_INIT: begin
          if (sync_reg[0]) begin
            st_reg     <= apcl_pkg::HST_IDLE;
            user_ready <= 1'b1;
          end
        end
        apcl_pkg::HST_IDLE: begin
          if (user_valid) begin
            user_ready             <= 1'b0;
            bus.host_data          <= user_data;
            bus.host_data_oe       <= 1'b1;
            bus.select_active_low  <= 1'b0;
            bus.select_active_high <= 1'b1;
            bus.write_strobe_n     <= 1'b0;
            st_reg                 <= apcl_pkg::HST_WRITE;
          end
        end
        apcl_pkg::HST_WRITE: begin
          // Margin of 2 cycles covers the device's synchroniser skew
          if (len_reg >= 8'(`APCL_WRITE_MIN_CYC + 2) &&
              rdy_cnt_reg >= 4'(`APCL_CONFIG_CLOCK_DIV)) begin
            bus.write_strobe_n     <= 1'b1;
            bus.select_active_low  <= 1'b1;
            bus.select_active_high <= 1'b0;
            st_reg                 <= apcl_pkg::HST_WAIT_BUSY;
          end
        end
        apcl_pkg::HST_WAIT_BUSY: begin
          bus.host_data_oe <= 1'b0;
          if (!sync_reg[1]) begin
            st_reg     <= apcl_pkg::HST_IDLE;
            user_ready <= 1'b1;
          end
        end
        default: st_reg <= apcl_pkg::HST_INIT;
      endcase
    end
  end
endmodule : apcl_host

// File: dv/apcl_chk.sv
`timescale 1ns/100ps
// ==================================================
// Pin link checker
module apcl_chk (
  input wire logic       clk,
  input wire logic       rst_n,
  input wire logic       select_active_low,
  input wire logic       select_active_high,
  input wire logic       write_strobe_n,
  input wire logic       read_strobe_n,
  input wire logic [7:0] host_data,
  input wire logic       dev_data_oe,
  input wire logic       rdy_busy,
  input wire logic       init_level,
  input wire logic       config_clock
);
  logic [7:0] busy_cnt_reg;
  logic [7:0] rdy_cnt_reg;
  logic       armed_reg;

  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);

  // ==================================================
  // Helpers
  // Low-cycle count, saturating so a long busy spell never wraps
  always_ff @(posedge clk) begin
    if (!rst_n || rdy_busy) busy_cnt_reg <= 8'h00;
    else if (busy_cnt_reg != 8'hff) busy_cnt_reg <= busy_cnt_reg + 8'h01;
  end
  // High-cycle count of ready
  always_ff @(posedge clk) begin
    if (!rst_n || !rdy_busy) rdy_cnt_reg <= 8'h00;
    else if (rdy_cnt_reg != 8'hff) rdy_cnt_reg <= rdy_cnt_reg + 8'h01;
  end
  // Busy before the first write is the init clear, not a byte
  always_ff @(posedge clk) begin
    if (!rst_n) armed_reg <= 1'b0;
    else if ($rose(write_strobe_n)) armed_reg <= 1'b1;
  end

  sequence s_write;
    !select_active_low && select_active_high &&
      !write_strobe_n && read_strobe_n;
  endsequence

  // ==================================================
  // Properties
  property p_write_len;
    $fell(write_strobe_n) |-> s_write[*8] ##1 s_write[*2];
  endproperty
  a_write_len: assert property (p_write_len)
    else $error("write shorter than 100 ns");
  property p_end_busy;
    $rose(write_strobe_n) |-> ##[1:6] !rdy_busy;
  endproperty
  a_end_busy: assert property (p_end_busy)
    else $error("busy late after write");
  property p_busy_min;
    $rose(rdy_busy) && armed_reg |-> busy_cnt_reg >= 8'h10;
  endproperty
  a_busy_min: assert property (p_busy_min)
    else $error("busy too short");
  property p_busy_max;
    armed_reg && !rdy_busy |-> busy_cnt_reg <= 8'h48;
  endproperty
  a_busy_max: assert property (p_busy_max)
    else $error("busy too long");
  property p_hold_ready;
    $rose(write_strobe_n) |-> rdy_cnt_reg >= 8'h08;
  endproperty
  a_hold_ready: assert property (p_hold_ready)
    else $error("write ended early");
  property p_init_wait;
    !init_level |-> write_strobe_n;
  endproperty
  a_init_wait: assert property (p_init_wait)
    else $error("write during init");
  property p_data_hold;
    !write_strobe_n && !$past(write_strobe_n) |-> $stable(host_data);
  endproperty
  a_data_hold: assert property (p_data_hold)
    else $error("data moved in write");
  property p_config_clock_shape;
    $rose(config_clock) |-> config_clock[*4] ##1 !config_clock[*4]
      ##1 config_clock;
  endproperty
  a_config_clock_shape: assert property (p_config_clock_shape)
    else $error("config clock period wrong");
  property p_no_read_drive;
    read_strobe_n[*4] |-> !dev_data_oe;
  endproperty
  a_no_read_drive: assert property (p_no_read_drive)
    else $error("bus driven without read");

  c_write: cover property ($rose(write_strobe_n));
  c_busy_end: cover property ($rose(rdy_busy) && armed_reg);
  c_long: cover property (armed_reg && busy_cnt_reg == 8'h20);
  c_early_write: cover property ($fell(write_strobe_n) && !rdy_busy);
endmodule : apcl_chk

// File: dv/async_peripheral_config_load_tb.sv
`timescale 1ns/100ps
// ==================================================
// Host and device joined, plus a hand-driven device
module async_peripheral_config_load_tb;
  logic       clk             = 1'b0;
  logic       rst_n           = 1'b0;
  logic       user_valid      = 1'b0;
  logic [7:0] user_data       = 8'h00;
  logic       user_ready;
  logic       cfg_bit;
  logic       cfg_bit_valid;
  logic       cfg_bit_b;
  logic       cfg_bit_valid_b;
  logic       write_dropped_b;
  logic       init_busy_a;
  logic       write_dropped_a;
  logic       ser_q[$];
  int         drop_a_cnt      = 0;
  logic       bits_q[$];
  logic       bits_b_q[$];
  int         busy_q[$];
  int         busy_len        = 0;
  int         drop_cnt        = 0;
  int         n_fail          = 0;
  int         cmp_count       = 0;
  int         cyc             = 0;

  apcl_if apcl_if_inst ();
  apcl_if apcl_if_inst_b ();
  always #5 clk = ~clk;

  apcl_host apcl_host_inst (
    .clk        (clk),
    .rst_n      (rst_n),
    .bus        (apcl_if_inst.host),
    .user_valid (user_valid),
    .user_data  (user_data),
    .user_ready (user_ready)
  );
  apcl_device apcl_device_inst (
    .clk           (clk),
    .rst_n         (rst_n),
    .bus           (apcl_if_inst.device),
    .cfg_bit       (cfg_bit),
    .cfg_bit_valid (cfg_bit_valid),
    .init_busy     (init_busy_a),
    .write_dropped (write_dropped_a)
  );
  // Second device faces the bench, which breaks the write rules
  apcl_device apcl_device_inst_b (
    .clk           (clk),
    .rst_n         (rst_n),
    .bus           (apcl_if_inst_b.device),
    .cfg_bit       (cfg_bit_b),
    .cfg_bit_valid (cfg_bit_valid_b),
    .init_busy     (),
    .write_dropped (write_dropped_b)
  );
  apcl_chk apcl_chk_inst (
    .clk                (clk),
    .rst_n              (rst_n),
    .select_active_low  (apcl_if_inst.select_active_low),
    .select_active_high (apcl_if_inst.select_active_high),
    .write_strobe_n     (apcl_if_inst.write_strobe_n),
    .read_strobe_n      (apcl_if_inst.read_strobe_n),
    .host_data          (apcl_if_inst.host_data),
    .dev_data_oe        (apcl_if_inst.dev_data_oe),
    .rdy_busy           (apcl_if_inst.rdy_busy),
    .init_level         (apcl_if_inst.init_level),
    .config_clock       (apcl_if_inst.config_clock)
  );

  // Monitors; timeout last so nothing runs after it
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cfg_bit_valid === 1'b1) bits_q.push_back(cfg_bit);
    if (cfg_bit_valid === 1'b1) ser_q.push_back(apcl_if_inst.serial_out);
    if (write_dropped_a === 1'b1) drop_a_cnt++;
    if (cfg_bit_valid_b === 1'b1) bits_b_q.push_back(cfg_bit_b);
    if (write_dropped_b === 1'b1) drop_cnt++;
    if (apcl_if_inst.rdy_busy === 1'b0) busy_len++;
    else if (busy_len > 0) begin
      busy_q.push_back(busy_len);
      busy_len = 0;
    end
    if (cyc == 5000) begin
      n_fail++;
      $display("CHECK FAILED %0t timeout", $time);
      wrap_up();
    end
  end

  // ==================================================
  // Shared tasks
  task automatic chk(input logic ok, input string msg);
    cmp_count++;
    if (ok !== 1'b1) begin
      n_fail++;
      $display("CHECK FAILED %0t %s", $time, msg);
    end
  endtask : chk

  task automatic wrap_up();
    $display("checks %0d failures %0d", cmp_count, n_fail);
    if (n_fail == 0 && cmp_count > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask : wrap_up

  task automatic send(input logic [7:0] b);
    int i;
    for (i = 0; i < 500 && user_ready !== 1'b1; i++) @(negedge clk);
    user_valid = 1'b1;
    user_data  = b;
    @(negedge clk);
    user_valid = 1'b0;
  endtask : send

  // Waits for the bits, then past any busy spell
  task automatic settle(input int nb);
    int i;
    for (i = 0; i < 900 && (bits_q.size() < nb || user_ready !== 1'b1); i++)
      @(negedge clk);
    repeat (80) @(negedge clk);
  endtask : settle

  task automatic pins_b(input logic sel, input logic ws, input logic rs);
    apcl_if_inst_b.select_active_low  = ~sel;
    apcl_if_inst_b.select_active_high = sel;
    apcl_if_inst_b.write_strobe_n     = ws;
    apcl_if_inst_b.read_strobe_n      = rs;
  endtask : pins_b

  // Data is released together with the strobe edge
  task automatic pin_wr(input logic [7:0] b, input int n);
    apcl_if_inst_b.host_data    = b;
    apcl_if_inst_b.host_data_oe = 1'b1;
    pins_b(1'b1, 1'b0, 1'b1);
    repeat (n) @(negedge clk);
    pins_b(1'b0, 1'b1, 1'b1);
    apcl_if_inst_b.host_data_oe = 1'b0;
  endtask : pin_wr

  // ==================================================
  // Scenarios
  task automatic t_init();
    int i;
    chk(apcl_if_inst.init_level === 1'b0, "init not low");
    chk(user_ready === 1'b0, "host ready in init");
    chk(init_busy_a === 1'b1, "init clear not shown");
    for (i = 0; i < 200 && user_ready !== 1'b1; i++) @(negedge clk);
    chk(apcl_if_inst.init_level === 1'b1, "init still low");
    chk(init_busy_a === 1'b0, "init clear stuck");
    $display("t_init done");
  endtask : t_init

  task automatic t_empty();
    logic [7:0] w;
    int i;
    w = 8'ha5;
    bits_q.delete();
    ser_q.delete();
    busy_q.delete();
    send(w);
    settle(8);
    for (i = 0; i < 8; i++) chk(bits_q[i] === w[7-i], "bit order");
    for (i = 0; i < 8; i++) chk(ser_q[i] === w[7-i], "chain out");
    chk(busy_q.size() == 1 && busy_q[0] >= 16, "short busy");
    chk(busy_q[0] <= 72, "empty busy over 9 periods");
    $display("t_empty done");
  endtask : t_empty

  task automatic t_full();
    logic [15:0] w;
    int i;
    w = 16'h3cc3;
    bits_q.delete();
    busy_q.delete();
    send(w[15:8]);
    send(w[7:0]);
    settle(16);
    for (i = 0; i < 16; i++) chk(bits_q[i] === w[15-i], "stream");
    chk(busy_q.size() == 2 && busy_q[1] > busy_q[0], "no stretch");
    chk(busy_q[1] <= 72, "busy over 9 periods");
    chk(drop_a_cnt == 0, "host write refused");
    $display("t_full done");
  endtask : t_full

  task automatic t_refuse();
    logic [7:0] w;
    int i;
    w = 8'h81;
    for (i = 0; i < 200 && apcl_if_inst_b.init_level !== 1'b1; i++)
      @(negedge clk);
    pin_wr(8'h5a, 5);
    repeat (20) @(negedge clk);
    chk(drop_cnt == 1, "short write kept");
    pin_wr(w, 12);
    for (i = 0; i < 20 && apcl_if_inst_b.rdy_busy !== 1'b0; i++)
      @(negedge clk);
    chk(i <= 6, "busy late");
    for (i = 0; i < 300 && bits_b_q.size() < 8; i++) @(negedge clk);
    for (i = 0; i < 8; i++) chk(bits_b_q[i] === w[7-i], "captured");
    chk(drop_cnt == 1, "good write dropped");
    $display("t_refuse done");
  endtask : t_refuse

  task automatic t_read();
    logic [7:0] st;
    int         i;
    pins_b(1'b1, 1'b1, 1'b0);
    for (i = 0; i < 20 && apcl_if_inst_b.dev_data_oe !== 1'b1; i++)
      @(negedge clk);
    chk(i <= 6, "status late");
    st = apcl_if_inst_b.data_bus;
    chk(st === 8'h01, "status byte");
    pins_b(1'b0, 1'b1, 1'b1);
    repeat (6) @(negedge clk);
    chk(apcl_if_inst_b.dev_data_oe === 1'b0, "bus held");
    $display("t_read done");
  endtask : t_read

  // Main sequence
  initial begin
    pins_b(1'b0, 1'b1, 1'b1);
    apcl_if_inst_b.host_data    = 8'h00;
    apcl_if_inst_b.host_data_oe = 1'b0;
    repeat (20) @(negedge clk);
    rst_n = 1'b1;
    t_init();
    t_empty();
    t_full();
    t_refuse();
    t_read();
    wrap_up();
  end
endmodule : async_peripheral_config_load_tb
